/* File: fcl_loader.sv */
// Fuse configuration loader: start-up copy into live configuration and read access
`timescale 1ns/100ps
`default_nettype none
module fcl_loader
    import fcl_pkg::*;
(
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic cpu_read_in,
    input wire logic cpu_write_in,
    input wire logic [3:0] cpu_addr_in,
    input wire logic [7:0] cpu_wdata_in,
    output logic [7:0] cpu_rdata_out,
    output logic cpu_rvalid_out,
    input wire logic debug_read_in,
    input wire logic debug_write_in,
    input wire logic debug_clear_in,
    input wire logic [3:0] debug_addr_in,
    input wire logic [7:0] debug_wdata_in,
    output logic [7:0] debug_rdata_out,
    output logic debug_rvalid_out,
    input wire logic chip_erase_in,
    output logic cpu_hold_out,
    output fcl_config_s config_out,
    output logic brownout_enable_out,
    output logic brownout_level_reserved_out,
    output logic brownout_sleep_reserved_out,
    output logic eeprom_erase_out,
    output logic flash_erase_out
);

    // ----------------------------------------
    // Fuse cells
    // ----------------------------------------
    logic [3:0] load_addr;
    logic [7:0] load_data;
    logic [7:0] cpu_cell;
    logic [7:0] debug_cell;

    // CPU write strobe and data never reach the cells; a nonzero write only masks cpu_rvalid_out
    fcl_fuse_array u_cells (
        .clock_in(clock_in),
        .program_in(debug_write_in), // R01
        .clear_in(debug_clear_in), // R01
        .program_addr_in(debug_addr_in),
        .program_data_in(debug_wdata_in),
        .load_addr_in(load_addr),
        .cpu_addr_in(cpu_addr_in),
        .debug_addr_in(debug_addr_in),
        .load_data_out(load_data),
        .cpu_data_out(cpu_cell),
        .debug_data_out(debug_cell)
    );

    logic cpu_write_ignored;
    assign cpu_write_ignored = cpu_write_in & (|cpu_wdata_in); // R01

    // ----------------------------------------
    // Start-up sequencer
    // ----------------------------------------
    fcl_state_e state;
    logic [3:0] next_load_addr;

    assign next_load_addr = 4'(load_addr + 4'h1);

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state <= FCL_ST_LOAD;
            load_addr <= FCL_OFF_WATCHDOG;
        end else begin
            unique case (state)
                FCL_ST_LOAD: begin
                    if (load_addr == FCL_OFF_LAST) begin
                        state <= FCL_ST_RUN; // R02
                    end else begin
                        load_addr <= next_load_addr;
                    end
                end
                FCL_ST_RUN: begin
                    state <= FCL_ST_RUN;
                end
                default: begin
                    state <= FCL_ST_LOAD;
                end
            endcase
        end
    end

    // Execution stays held until the last fuse byte has landed
    assign cpu_hold_out = (state != FCL_ST_RUN); // R18

    // ----------------------------------------
    // Live configuration copy
    // ----------------------------------------
    // Only written while loading, so later programming has no effect until reset
    logic loading;
    assign loading = (state == FCL_ST_LOAD); // R03

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            config_out <= FCL_CONFIG_RESET;
        end else if (loading) begin
            unique case (load_addr)
                FCL_OFF_WATCHDOG: begin
                    config_out.watchdog_window <= load_data[FCL_WINDOW_LSB +: 4]; // R05
                    config_out.watchdog_period <= load_data[FCL_PERIOD_LSB +: 4]; // R06
                end
                FCL_OFF_BROWNOUT: begin
                    config_out.threshold_level <= load_data[FCL_LEVEL_LSB +: 3]; // R07
                    config_out.sample_rate_select <= load_data[FCL_SAMPLE_BIT]; // R09
                    config_out.active_mode <= fcl_bo_mode_e'(load_data[FCL_ACTIVE_LSB +: 2]); // R10
                    config_out.sleep_mode <= fcl_bo_mode_e'(load_data[FCL_SLEEP_LSB +: 2]); // R11
                end
                FCL_OFF_OSCILLATOR: begin
                    config_out.fast_osc_rate_select <= load_data[FCL_OSC_RATE_BIT]; // R12
                end
                FCL_OFF_SYSTEM_ZERO: begin
                    config_out.scan_region_select <= fcl_scan_e'(load_data[FCL_SCAN_REGION_LSB +: 2]); // R13
                    config_out.polynomial_select <= load_data[FCL_POLY_BIT]; // R14
                    config_out.debug_pin_role <= load_data[FCL_DEBUG_PIN_BIT]; // R15
                    config_out.reset_pin_role <= load_data[FCL_RESET_PIN_BIT]; // R16
                    config_out.eeprom_keep_on_erase <= load_data[FCL_EEPROM_KEEP_BIT]; // R17
                end
                FCL_OFF_CODE_SIZE: begin
                    config_out.code_region_size <= load_data; // R02
                end
                FCL_OFF_BOOT_SIZE: begin
                    config_out.boot_region_size <= load_data; // R02
                end
                default: begin
                    config_out <= config_out;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Derived brown-out and erase controls
    // ----------------------------------------
    // Lowest code behaves as disabled outside chip erase
    always_comb begin
        if (config_out.threshold_level == FCL_LEVEL_LOWEST) begin
            brownout_enable_out = chip_erase_in; // R08
        end else begin
            brownout_enable_out = (config_out.active_mode != FCL_MODE_DISABLED); // R10
        end
    end

    assign brownout_level_reserved_out = (config_out.threshold_level > FCL_LEVEL_HIGHEST); // R07
    assign brownout_sleep_reserved_out = (config_out.sleep_mode == FCL_SLEEP_RESERVED); // R11
    assign flash_erase_out = chip_erase_in;
    assign eeprom_erase_out = chip_erase_in & ~config_out.eeprom_keep_on_erase; // R17

    // ----------------------------------------
    // Read ports
    // ----------------------------------------
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cpu_rdata_out <= FCL_UNMAPPED_READ;
            cpu_rvalid_out <= 1'b0;
        end else begin
            cpu_rvalid_out <= cpu_read_in & ~cpu_write_ignored; // R01
            if (cpu_read_in) begin
                cpu_rdata_out <= cpu_cell;
            end
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            debug_rdata_out <= FCL_UNMAPPED_READ;
            debug_rvalid_out <= 1'b0;
        end else begin
            debug_rvalid_out <= debug_read_in; // R01
            if (debug_read_in) begin
                debug_rdata_out <= debug_cell;
            end
        end
    end

endmodule // fcl_loader
`default_nettype wire

/* File: fcl_pkg.sv */
// Package for the fuse configuration loader: offsets, fields, codes and live configuration carrier
// Contract
// [R01] CPU and debug port read; debug only writes. A CPU read with a nonzero CPU write in the same cycle gets no rvalid.
// [R02] Copy each fuse to its target at start-up end. The system one fuse at offset 6 has no target and is never copied.
// [R03] New fuse values act only after reset reload.
// [R04] Programmer writes reserved fuse bits as one.
// [R05] Watchdog fuse bits 7:4 load window field.
// [R06] Watchdog fuse bits 3:0 load period field.
// [R07] Brown-out bits 7:5 load threshold; codes 0-3.
// [R08] Threshold code zero acts only during chip erase.
// [R09] Bit 4 selects 128 Hz or 32 Hz sampling.
// [R10] Bits 3:2 set active and idle brown-out mode.
// [R11] Bits 1:0 set sleep brown-out mode.
// [R12] Oscillator bit 3 selects 20 or 16 MHz.
// [R13] System bits 7:6 pick the CRC scan region.
// [R14] System bit 5 picks CRC16 or CRC32 polynomial.
// [R15] System bit 4 sets debug pin start-up role.
// [R16] System bit 3 sets reset pin start-up role.
// [R17] System bit 0 keeps EEPROM across chip erase.
// [R18] Hold code execution until all fuses loaded.
package fcl_pkg;

    // ----------------------------------------
    // Fuse map
    // ----------------------------------------
    localparam int FCL_FUSE_COUNT = 9;
    localparam int FCL_ADDR_W = 4;
    localparam logic [3:0] FCL_OFF_WATCHDOG = 4'h0;
    localparam logic [3:0] FCL_OFF_BROWNOUT = 4'h1;
    localparam logic [3:0] FCL_OFF_OSCILLATOR = 4'h2;
    localparam logic [3:0] FCL_OFF_SYSTEM_ZERO = 4'h5;
    localparam logic [3:0] FCL_OFF_SYSTEM_ONE = 4'h6;
    localparam logic [3:0] FCL_OFF_CODE_SIZE = 4'h7;
    localparam logic [3:0] FCL_OFF_BOOT_SIZE = 4'h8;
    localparam logic [3:0] FCL_OFF_LAST = 4'h8;

    // Factory values; erased cells read as all ones
    localparam logic [7:0] FCL_FACTORY_WATCHDOG = 8'h00;
    localparam logic [7:0] FCL_FACTORY_BROWNOUT = 8'h00;
    localparam logic [7:0] FCL_FACTORY_OSCILLATOR = 8'h00;
    localparam logic [7:0] FCL_FACTORY_SYSTEM_ZERO = 8'hD0;
    localparam logic [7:0] FCL_FACTORY_SYSTEM_ONE = 8'h07;
    localparam logic [7:0] FCL_FACTORY_SIZE = 8'h00;
    localparam logic [7:0] FCL_ERASED = 8'hFF;
    localparam logic [7:0] FCL_UNMAPPED_READ = 8'h00;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int FCL_WINDOW_LSB = 4;
    localparam int FCL_PERIOD_LSB = 0;
    localparam int FCL_LEVEL_LSB = 5;
    localparam int FCL_SAMPLE_BIT = 4;
    localparam int FCL_ACTIVE_LSB = 2;
    localparam int FCL_SLEEP_LSB = 0;
    localparam int FCL_OSC_RATE_BIT = 3;
    localparam int FCL_SCAN_REGION_LSB = 6;
    localparam int FCL_POLY_BIT = 5;
    localparam int FCL_DEBUG_PIN_BIT = 4;
    localparam int FCL_RESET_PIN_BIT = 3;
    localparam int FCL_EEPROM_KEEP_BIT = 0;

    // ----------------------------------------
    // Codes
    // ----------------------------------------
    localparam logic [2:0] FCL_LEVEL_LOWEST = 3'h0;
    localparam logic [2:0] FCL_LEVEL_HIGHEST = 3'h3;
    localparam logic [1:0] FCL_SLEEP_RESERVED = 2'h3;

    typedef enum logic [1:0] {
        FCL_MODE_DISABLED = 2'h0,
        FCL_MODE_CONTINUOUS = 2'h1,
        FCL_MODE_SAMPLED = 2'h2,
        FCL_MODE_CONTINUOUS_HOLD = 2'h3
    } fcl_bo_mode_e;

    typedef enum logic [1:0] {
        FCL_SCAN_WHOLE_FLASH = 2'h0,
        FCL_SCAN_BOOT = 2'h1,
        FCL_SCAN_BOOT_PLUS_APP = 2'h2,
        FCL_SCAN_SKIPPED = 2'h3
    } fcl_scan_e;

    typedef enum logic [1:0] {
        FCL_ST_LOAD = 2'b00,
        FCL_ST_RUN = 2'b01
    } fcl_state_e;

    // Live configuration as seen by the peripherals
    typedef struct packed {
        logic [3:0] watchdog_window;
        logic [3:0] watchdog_period;
        logic [2:0] threshold_level;
        logic sample_rate_select;
        fcl_bo_mode_e active_mode;
        fcl_bo_mode_e sleep_mode;
        logic fast_osc_rate_select;
        fcl_scan_e scan_region_select;
        logic polynomial_select;
        logic debug_pin_role;
        logic reset_pin_role;
        logic eeprom_keep_on_erase;
        logic [7:0] code_region_size;
        logic [7:0] boot_region_size;
    } fcl_config_s;

    localparam fcl_config_s FCL_CONFIG_RESET = '0;

endpackage

/* File: fcl_fuse_array.sv */
// Nonvolatile fuse cell array with one program port and three read ports
`timescale 1ns/100ps
`default_nettype none
module fcl_fuse_array
    import fcl_pkg::*;
(
    input wire logic clock_in,
    input wire logic program_in,
    input wire logic clear_in,
    input wire logic [3:0] program_addr_in,
    input wire logic [7:0] program_data_in,
    input wire logic [3:0] load_addr_in,
    input wire logic [3:0] cpu_addr_in,
    input wire logic [3:0] debug_addr_in,
    output logic [7:0] load_data_out,
    output logic [7:0] cpu_data_out,
    output logic [7:0] debug_data_out
);

    // Cells carry no reset: their content must survive every device reset
    // Power-up content is the factory image; the reserved cells read as erased.
    // A declaration value, not an initial process, so that only the update process writes the cells.
    logic [7:0] cells [FCL_FUSE_COUNT] = '{
        FCL_FACTORY_WATCHDOG,
        FCL_FACTORY_BROWNOUT,
        FCL_FACTORY_OSCILLATOR,
        FCL_ERASED,
        FCL_ERASED,
        FCL_FACTORY_SYSTEM_ZERO,
        FCL_FACTORY_SYSTEM_ONE,
        FCL_FACTORY_SIZE,
        FCL_FACTORY_SIZE
    };

    function automatic logic [7:0] read_cell(input logic [3:0] addr);
        logic [7:0] value;
        value = FCL_UNMAPPED_READ;
        if (addr <= FCL_OFF_LAST) begin
            value = cells[addr];
        end
        return value;
    endfunction

    // Clear takes priority over a program in the same cycle
    always_ff @(posedge clock_in) begin
        if (clear_in) begin
            for (int i = 0; i < FCL_FUSE_COUNT; i++) begin
                cells[i] <= FCL_ERASED;
            end
        end else if (program_in && program_addr_in <= FCL_OFF_LAST) begin
            cells[program_addr_in] <= program_data_in;
        end
    end

    // Combinational processes, so a freshly programmed cell shows without an address change
    always_comb begin
        load_data_out = read_cell(load_addr_in);
    end

    always_comb begin
        cpu_data_out = read_cell(cpu_addr_in);
    end

    always_comb begin
        debug_data_out = read_cell(debug_addr_in);
    end

endmodule // fcl_fuse_array
`default_nettype wire

/* File: fcl_loader_properties.sv */
// Port-level checks for the fuse configuration loader
`timescale 1ns/100ps
`default_nettype none
module fcl_loader_properties
    import fcl_pkg::*;
(
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic cpu_read_in,
    input wire logic cpu_write_in,
    input wire logic [3:0] cpu_addr_in,
    input wire logic [7:0] cpu_rdata_out,
    input wire logic cpu_rvalid_out,
    input wire logic debug_read_in,
    input wire logic debug_rvalid_out,
    input wire logic chip_erase_in,
    input wire logic cpu_hold_out,
    input wire fcl_config_s config_out,
    input wire logic brownout_enable_out,
    input wire logic brownout_level_reserved_out,
    input wire logic brownout_sleep_reserved_out,
    input wire logic eeprom_erase_out,
    input wire logic flash_erase_out
);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);

    chk_hold_release: assert property ($rose(resetn_in) |-> cpu_hold_out [*8] ##[1:2] !cpu_hold_out)
        else $error("hold not released after load");
    chk_hold_stays: assert property (!cpu_hold_out |=> !cpu_hold_out)
        else $error("hold rose outside reset");
    chk_config_frozen: assert property (!cpu_hold_out && !$past(cpu_hold_out) |-> $stable(config_out))
        else $error("live configuration moved");
    chk_cpu_answer: assert property (cpu_read_in && !cpu_write_in |=> cpu_rvalid_out)
        else $error("cpu read not answered");
    chk_cpu_unmapped: assert property (cpu_read_in && !cpu_write_in && cpu_addr_in > 4'h8
        |=> cpu_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    chk_debug_answer: assert property (debug_read_in |=> debug_rvalid_out)
        else $error("debug read not answered");
    chk_lowest_level: assert property (config_out.threshold_level == 3'h0 |-> brownout_enable_out == chip_erase_in)
        else $error("lowest level enable wrong");
    chk_level_flag: assert property (brownout_level_reserved_out == (config_out.threshold_level > 3'h3))
        else $error("level reserved flag wrong");
    chk_sleep_flag: assert property (brownout_sleep_reserved_out == (config_out.sleep_mode == FCL_MODE_CONTINUOUS_HOLD))
        else $error("sleep reserved flag wrong");
    chk_erase_split: assert property (chip_erase_in |-> flash_erase_out && eeprom_erase_out != config_out.eeprom_keep_on_erase)
        else $error("erase split wrong");
endmodule // fcl_loader_properties
`default_nettype wire

/* File: fcl_programmer.sv */
// Model of the external programmer on the single-pin debug port
`timescale 1ns/100ps
`default_nettype none
module fcl_programmer
    import fcl_pkg::*;
(
    input wire logic clock_in,
    input wire logic [7:0] rdata_in,
    input wire logic rvalid_in,
    output logic read_out,
    output logic write_out,
    output logic clear_out,
    output logic [3:0] addr_out,
    output logic [7:0] wdata_out
);
    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    initial begin
        {read_out, write_out, clear_out, addr_out, wdata_out} = '0;
    end

    function automatic logic [7:0] rsvd(input logic [3:0] a);
        case (a)
            4'h2: rsvd = 8'hF7;
            4'h5: rsvd = 8'h06;
            4'h6: rsvd = 8'hF8;
            4'h3, 4'h4: rsvd = 8'hFF;
            default: rsvd = 8'h00;
        endcase
    endfunction

    // Idle lines show the inverse so no stale value can pass for data
    task automatic prog(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_in);
        write_out <= 1'b1;
        addr_out <= a;
        wdata_out <= d | rsvd(a);
        @(posedge clock_in);
        write_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~(d | rsvd(a));
    endtask

    task automatic clear_all();
        @(posedge clock_in);
        clear_out <= 1'b1;
        @(posedge clock_in);
        clear_out <= 1'b0;
    endtask

    task automatic peek(input logic [3:0] a, output logic v, output logic [7:0] d);
        @(posedge clock_in);
        read_out <= 1'b1;
        addr_out <= a;
        @(posedge clock_in);
        read_out <= 1'b0;
        addr_out <= ~a;
        #1;
        v = rvalid_in;
        d = rdata_in;
    endtask
endmodule // fcl_programmer
`default_nettype wire

/* File: fcl_loader_tb.sv */
// Self-checking testbench for the fuse configuration loader
`timescale 1ns/100ps
`default_nettype none
module fcl_loader_tb;
    import fcl_pkg::*;
    logic clock_in, resetn_in, cpu_read_in, cpu_write_in, cpu_rvalid_out, chip_erase_in, cpu_hold_out;
    logic dbg_rd, dbg_wr, dbg_clr, dbg_rv, bo_en, lvl_rsv, slp_rsv, ee_er, fl_er, pv;
    logic [3:0] cpu_addr_in, dbg_addr;
    logic [7:0] cpu_wdata_in, cpu_rdata_out, dbg_wd, dbg_rdata, pd;
    fcl_config_s config_out;
    int fail_count = 0, check_count = 0, cycles = 0;
    logic [7:0] factory [9] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hD0, 8'h07, 8'h00, 8'h00};

    fcl_loader dut_u (.clock_in(clock_in), .resetn_in(resetn_in), .cpu_read_in(cpu_read_in),
        .cpu_write_in(cpu_write_in), .cpu_addr_in(cpu_addr_in), .cpu_wdata_in(cpu_wdata_in),
        .cpu_rdata_out(cpu_rdata_out), .cpu_rvalid_out(cpu_rvalid_out), .debug_read_in(dbg_rd),
        .debug_write_in(dbg_wr), .debug_clear_in(dbg_clr), .debug_addr_in(dbg_addr), .debug_wdata_in(dbg_wd),
        .debug_rdata_out(dbg_rdata), .debug_rvalid_out(dbg_rv), .chip_erase_in(chip_erase_in),
        .cpu_hold_out(cpu_hold_out), .config_out(config_out), .brownout_enable_out(bo_en),
        .brownout_level_reserved_out(lvl_rsv), .brownout_sleep_reserved_out(slp_rsv),
        .eeprom_erase_out(ee_er), .flash_erase_out(fl_er));
    fcl_programmer prog_u (.clock_in(clock_in), .rdata_in(dbg_rdata), .rvalid_in(dbg_rv), .read_out(dbg_rd),
        .write_out(dbg_wr), .clear_out(dbg_clr), .addr_out(dbg_addr), .wdata_out(dbg_wd));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    function automatic fcl_config_s exp_cfg(input logic [7:0] w, b, o, s, c, t);
        exp_cfg = FCL_CONFIG_RESET;
        {exp_cfg.watchdog_window, exp_cfg.watchdog_period} = w;
        {exp_cfg.threshold_level, exp_cfg.sample_rate_select} = b[7:4];
        exp_cfg.active_mode = fcl_bo_mode_e'(b[3:2]);
        exp_cfg.sleep_mode = fcl_bo_mode_e'(b[1:0]);
        exp_cfg.fast_osc_rate_select = o[3];
        exp_cfg.scan_region_select = fcl_scan_e'(s[7:6]);
        {exp_cfg.polynomial_select, exp_cfg.debug_pin_role, exp_cfg.reset_pin_role} = s[5:3];
        exp_cfg.eeprom_keep_on_erase = s[0];
        exp_cfg.code_region_size = c;
        exp_cfg.boot_region_size = t;
    endfunction

    task automatic do_reset();
        @(posedge clock_in) resetn_in <= 1'b0;
        repeat (5) @(posedge clock_in);
        resetn_in <= 1'b1;
        repeat (5) @(posedge clock_in);
        #1 check(cpu_hold_out, 1'b1, "hold during load");
        repeat (6) @(posedge clock_in);
        #1 check(cpu_hold_out, 1'b0, "hold after load");
    endtask

    task automatic cpu_check(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock_in);
        cpu_read_in <= 1'b1;
        cpu_addr_in <= a;
        @(posedge clock_in);
        cpu_read_in <= 1'b0;
        #1 check(cpu_rvalid_out, 1'b1, "cpu rvalid");
        check(cpu_rdata_out, exp, "cpu rdata");
    endtask

    task automatic erase_check(input logic en, input logic ee);
        @(posedge clock_in) chip_erase_in <= 1'b1;
        #1 check({bo_en, ee_er, fl_er}, {en, ee, 1'b1}, "erase outputs");
        @(posedge clock_in) chip_erase_in <= 1'b0;
    endtask

    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            final_report();
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        {resetn_in, cpu_read_in, cpu_write_in, cpu_addr_in, cpu_wdata_in, chip_erase_in} = '0;
        do_reset();
        check(config_out, exp_cfg(8'h00, 8'h00, 8'h00, 8'hD0, 8'h00, 8'h00), "factory load");
        #1 check(bo_en, 1'b0, "level zero outside erase");
        erase_check(1'b1, 1'b1);
        for (int i = 0; i < 9; i++) cpu_check(4'(i), factory[i]);
        cpu_check(4'hF, 8'h00);
        @(posedge clock_in);
        cpu_write_in <= 1'b1;
        cpu_addr_in <= 4'h1;
        cpu_wdata_in <= 8'hAA;
        @(posedge clock_in) cpu_write_in <= 1'b0;
        cpu_check(4'h1, 8'h00);
        prog_u.prog(4'h0, 8'hA5);
        prog_u.prog(4'h1, 8'hEF);
        prog_u.prog(4'h2, 8'h08);
        prog_u.prog(4'h5, 8'h69);
        prog_u.prog(4'h6, 8'h00);
        prog_u.prog(4'h7, 8'h12);
        prog_u.prog(4'h8, 8'h34);
        prog_u.peek(4'h2, pv, pd);
        check({pv, pd}, {1'b1, 8'hFF}, "debug read");
        cpu_check(4'h6, 8'hF8);
        check(config_out, exp_cfg(8'h00, 8'h00, 8'h00, 8'hD0, 8'h00, 8'h00), "before reset");
        do_reset();
        check(config_out, exp_cfg(8'hA5, 8'hEF, 8'hFF, 8'h6F, 8'h12, 8'h34), "reload");
        check({lvl_rsv, slp_rsv}, 2'b11, "reserved flags");
        erase_check(1'b1, 1'b0);
        prog_u.clear_all();
        cpu_check(4'h0, 8'hFF);
        do_reset();
        check(config_out, exp_cfg(8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF), "erased load");
        final_report();
    end
endmodule // fcl_loader_tb

bind fcl_loader fcl_loader_properties chk_u (.clock_in(clock_in), .resetn_in(resetn_in),
    .cpu_read_in(cpu_read_in), .cpu_write_in(cpu_write_in), .cpu_addr_in(cpu_addr_in),
    .cpu_rdata_out(cpu_rdata_out), .cpu_rvalid_out(cpu_rvalid_out), .debug_read_in(debug_read_in),
    .debug_rvalid_out(debug_rvalid_out), .chip_erase_in(chip_erase_in), .cpu_hold_out(cpu_hold_out),
    .config_out(config_out), .brownout_enable_out(brownout_enable_out),
    .brownout_level_reserved_out(brownout_level_reserved_out),
    .brownout_sleep_reserved_out(brownout_sleep_reserved_out), .eeprom_erase_out(eeprom_erase_out),
    .flash_erase_out(flash_erase_out));
`default_nettype wire
